// [shared/reload_timer_defines.vh]
// Register offsets, field positions, reset values and timing counts of the reload timer.
`ifndef RELOAD_TIMER_DEFINES_VH
`define RELOAD_TIMER_DEFINES_VH
`define IDX_PORT3_FUNCTION_SELECT 12'h00b
`define IDX_MODULE_CLOCK_GATE 12'h00d
`define IDX_TIMER_MODE_CLOCK_SELECT 12'h014
`define IDX_TIMER_OUTPUT_MODE 12'h015
`define IDX_RELOAD_COUNT_LOW 12'h016
`define IDX_RELOAD_COUNT_HIGH 12'h017
`define IDX_OVERFLOW_FLAG 12'h018
`define IDX_TIMER_STATUS 12'h019
`define MODE_RELOAD_BIT 3
`define MODE_CLK_SEL_MSB 2
`define MODE_CLK_SEL_LSB 0
`define PORT3_TIMER_OUT_BIT 0
`define GATE_STOP_BIT 0
`define RESET_MODE 4'h0
`define RESET_OUTPUT_MODE 1'b0
`define RESET_RELOAD_LOW 4'h0
`define RESET_PORT3 4'h0
`define RESET_GATE 4'h0
`define MODE_DELAY_CYCLES 3'h2
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// [rtl/prescaler_tick.v]
// Prescaler that produces a one-cycle count tick for the selected division ratio.
`timescale 1ns/1ns
`include "reload_timer_defines.vh"
module prescaler_tick (
  input wire aclk, // System clock.
  input wire aresetn, // Synchronous reset, active low.
  input wire run, // Counting enabled (clock supplied).
  input wire [2:0] clk_sel, // Division select.
  output reg tick // One-cycle count pulse.
);
  reg [10:0] div_q;
  wire [10:0] div_d;
  reg tap;
  assign div_d = div_q + 11'h001;
  always @* begin
    case (clk_sel)
      3'h0: tap = (div_q[10:0] == 11'h7ff);
      3'h1: tap = (div_q[8:0] == 9'h1ff);
      3'h2: tap = (div_q[6:0] == 7'h7f);
      3'h3: tap = (div_q[4:0] == 5'h1f);
      3'h4: tap = (div_q[3:0] == 4'hf);
      3'h5: tap = (div_q[2:0] == 3'h7);
      3'h6: tap = (div_q[1:0] == 2'h3);
      default: tap = 1'b1;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 11'h000;
      tick <= 1'b0;
    end else if (run) begin
      div_q <= div_d;
      tick <= tap;
    end else begin
      tick <= 1'b0;
    end
  end
endmodule // prescaler_tick

// [rtl/wave_out.v]
// Toggle or PWM waveform generator driven by counter overflow and count.
`timescale 1ns/1ns
module wave_out (
  input wire aclk, // System clock.
  input wire aresetn, // Synchronous reset, active low.
  input wire pwm_mode, // 1 selects PWM, 0 toggle.
  input wire overflow, // Counter overflow pulse.
  input wire [7:0] count, // Live counter value.
  input wire [7:0] reload, // Reload value (PWM duty).
  output reg wave // Waveform level.
);
  always @(posedge aclk) begin
    if (!aresetn) begin
      wave <= 1'b0;
    end else if (pwm_mode) begin
      // High from overflow until the count matches the reload value.
      if (overflow) begin
        wave <= 1'b1;
      end else if (count == reload) begin
        wave <= 1'b0;
      end
    end else if (overflow) begin
      wave <= ~wave;
    end
  end
endmodule // wave_out

// [rtl/reload_timer.v]
// AXI4-Lite reload timer with prescaler, waveform output and overflow flag.
// Notes on behaviour
// - The 4-bit write-only mode register picks reload or free-run and the clock.
// - The mode register clears to zero on reset.
// - A new mode takes effect only two accesses after the write.
// - A one-bit write-only register picks toggle or PWM output and resets to zero.
// - The write-only reload value has a low digit reset to zero, the high one undefined.
// - The read-only count has two digits and its high digit reads the live counter.
// - Reload and count share two addresses: writes reload, reads count.
// - A write-only port bit chooses general port or timer output, reset to zero.
// - A write-only standby register gates the timer clock, zero meaning running.
// - A low-digit write leaves the counter; a high-digit write loads the whole value.
// - Reading the high digit latches the low half for the next low-digit read.
// - The counter steps per tick and after FF overflows to reload or zero.
// - Each overflow sets a flag held until software clears it or reset.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`include "reload_timer_defines.vh"
module reload_timer (
  input wire aclk, // System clock, 20 MHz.
  input wire aresetn, // Synchronous reset, active low.
  input wire [13:0] s_axi_awaddr, // Write address.
  input wire s_axi_awvalid, // Write address valid.
  output reg s_axi_awready, // Write address ready.
  input wire [31:0] s_axi_wdata, // Write data.
  input wire [3:0] s_axi_wstrb, // Write strobes.
  input wire s_axi_wvalid, // Write data valid.
  output reg s_axi_wready, // Write data ready.
  output reg [1:0] s_axi_bresp, // Write response.
  output reg s_axi_bvalid, // Write response valid.
  input wire s_axi_bready, // Write response ready.
  input wire [13:0] s_axi_araddr, // Read address.
  input wire s_axi_arvalid, // Read address valid.
  output reg s_axi_arready, // Read address ready.
  output reg [31:0] s_axi_rdata, // Read data.
  output reg [1:0] s_axi_rresp, // Read response.
  output reg s_axi_rvalid, // Read data valid.
  input wire s_axi_rready, // Read response ready.
  input wire port_out_level, // General port output level.
  output reg timer_output_pin, // Shared pin level.
  output reg overflow_irq_flag // Overflow flag level.
);
  reg [3:0] mode_q;
  reg [3:0] mode_act_q;
  reg [2:0] mode_dly_q;
  reg output_mode_q;
  reg [3:0] reload_lo_q;
  reg [3:0] reload_hi_q;
  reg [3:0] port3_q;
  reg [3:0] gate_q;
  reg [7:0] count_q;
  reg [3:0] latch_lo_q;
  reg [13:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aw_have_q;
  reg w_have_q;
  reg flag_clr;
  wire [11:0] widx;
  wire [11:0] ridx;
  wire wr_fire;
  wire rd_fire;
  wire wr_ok;
  wire wr_lane0;
  wire tick;
  wire run;
  wire at_top;
  wire overflow;
  wire wave;
  reg [31:0] rdata_d;
  reg rd_ok;
  assign widx = awaddr_q[13:2];
  assign ridx = s_axi_araddr[13:2];
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_lane0 = wstrb_q[0];
  assign wr_ok = (awaddr_q[1:0] == 2'b00) && ((widx == `IDX_PORT3_FUNCTION_SELECT) ||
    (widx == `IDX_MODULE_CLOCK_GATE) || (widx == `IDX_TIMER_MODE_CLOCK_SELECT) ||
    (widx == `IDX_TIMER_OUTPUT_MODE) || (widx == `IDX_RELOAD_COUNT_LOW) ||
    (widx == `IDX_RELOAD_COUNT_HIGH) || (widx == `IDX_OVERFLOW_FLAG));
  assign run = !gate_q[`GATE_STOP_BIT];
  assign at_top = (count_q == 8'hff);
  assign overflow = tick && at_top;

  // Write address and data are captured independently, in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 14'h0000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register writes; only byte lane 0 carries the 4-bit digits.
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= `RESET_MODE;
      output_mode_q <= `RESET_OUTPUT_MODE;
      reload_lo_q <= `RESET_RELOAD_LOW;
      port3_q <= `RESET_PORT3;
      gate_q <= `RESET_GATE;
    end else if (wr_fire && wr_ok && wr_lane0) begin
      case (widx)
        `IDX_TIMER_MODE_CLOCK_SELECT: mode_q <= wdata_q[3:0];
        `IDX_TIMER_OUTPUT_MODE: output_mode_q <= wdata_q[0];
        `IDX_RELOAD_COUNT_LOW: reload_lo_q <= wdata_q[3:0];
        `IDX_PORT3_FUNCTION_SELECT: port3_q <= wdata_q[3:0];
        `IDX_MODULE_CLOCK_GATE: gate_q <= wdata_q[3:0];
        default: gate_q <= gate_q;
      endcase
    end
  end

  // The upper reload digit has no reset value.
  always @(posedge aclk) begin
    if (wr_fire && wr_ok && wr_lane0 && widx == `IDX_RELOAD_COUNT_HIGH) begin
      reload_hi_q <= wdata_q[3:0];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_act_q <= `RESET_MODE;
      mode_dly_q <= 3'h0;
    end else if (wr_fire && wr_ok && wr_lane0 && widx == `IDX_TIMER_MODE_CLOCK_SELECT) begin
      mode_dly_q <= `MODE_DELAY_CYCLES;
    end else if (mode_dly_q != 3'h0) begin
      // Each later bus access stands for one executed instruction.
      if (wr_fire || rd_fire) begin
        mode_dly_q <= mode_dly_q - 3'h1;
      end
    end else begin
      mode_act_q <= mode_q;
    end
  end

  prescaler_tick u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .clk_sel(mode_act_q[`MODE_CLK_SEL_MSB:`MODE_CLK_SEL_LSB]),
    .tick(tick)
  );

  // Counter has no reset: its value is undefined until first loaded.
  always @(posedge aclk) begin
    if (wr_fire && wr_ok && wr_lane0 && widx == `IDX_RELOAD_COUNT_HIGH) begin
      count_q <= {wdata_q[3:0], reload_lo_q};
    end else if (tick) begin
      if (at_top) begin
        count_q <= mode_act_q[`MODE_RELOAD_BIT] ? {reload_hi_q, reload_lo_q} : 8'h00;
      end else begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      overflow_irq_flag <= 1'b0;
    end else if (overflow) begin
      overflow_irq_flag <= 1'b1;
    end else if (flag_clr) begin
      overflow_irq_flag <= 1'b0;
    end
  end

  always @* begin
    flag_clr = wr_fire && wr_ok && wr_lane0 && (widx == `IDX_OVERFLOW_FLAG) && !wdata_q[0];
  end

  wave_out u_wave (
    .aclk(aclk),
    .aresetn(aresetn),
    .pwm_mode(output_mode_q),
    .overflow(overflow),
    .count(count_q),
    .reload({reload_hi_q, reload_lo_q}),
    .wave(wave)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_pin <= port3_q[`PORT3_TIMER_OUT_BIT] ? wave : port_out_level;
    end
  end

  always @* begin
    rdata_d = 32'h00000000;
    rd_ok = (s_axi_araddr[1:0] == 2'b00);
    case (ridx)
      `IDX_RELOAD_COUNT_LOW: rdata_d[3:0] = latch_lo_q;
      `IDX_RELOAD_COUNT_HIGH: rdata_d[3:0] = count_q[7:4];
      `IDX_OVERFLOW_FLAG: rdata_d[0] = overflow_irq_flag;
      `IDX_TIMER_STATUS: rdata_d[4:0] = {(mode_dly_q != 3'h0), mode_act_q};
      // Write-only registers read as zero.
      `IDX_PORT3_FUNCTION_SELECT: rdata_d = 32'h00000000;
      `IDX_MODULE_CLOCK_GATE: rdata_d = 32'h00000000;
      `IDX_TIMER_MODE_CLOCK_SELECT: rdata_d = 32'h00000000;
      `IDX_TIMER_OUTPUT_MODE: rdata_d = 32'h00000000;
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Low half is captured when the high digit is read.
  always @(posedge aclk) begin
    if (rd_fire && ridx == `IDX_RELOAD_COUNT_HIGH) begin
      latch_lo_q <= count_q[3:0];
    end
  end
endmodule // reload_timer

// [sim/reload_timer_assertions.sv]
// Bus handshake, pin and flag checks for the reload timer.
`timescale 1ns/1ns
module reload_timer_checker (
  input wire aclk, // Clock.
  input wire aresetn, // Reset, active low.
  input wire [13:0] s_axi_awaddr, // Write address.
  input wire s_axi_awvalid, // AW valid.
  input wire s_axi_awready, // AW ready.
  input wire [31:0] s_axi_wdata, // Write data.
  input wire s_axi_wvalid, // W valid.
  input wire s_axi_wready, // W ready.
  input wire [1:0] s_axi_bresp, // B response.
  input wire s_axi_bvalid, // B valid.
  input wire s_axi_bready, // B ready.
  input wire s_axi_arvalid, // AR valid.
  input wire s_axi_arready, // AR ready.
  input wire [31:0] s_axi_rdata, // Read data.
  input wire s_axi_rvalid, // R valid.
  input wire s_axi_rready, // R ready.
  input wire port_out_level, // Port level.
  input wire timer_output_pin, // Pin.
  input wire overflow_irq_flag // Flag.
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg sel_q;
  // Mirror of the port function bit, all bench writes use full strobes.
  always @(posedge aclk) begin
    if (!aresetn) sel_q <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 14'h2c)
      sel_q <= s_axi_wdata[0];
  end
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
  property p_b_follows; s_wr |-> ##2 s_axi_bvalid; endproperty
  property p_r_follows; s_rd |=> s_axi_rvalid; endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_w_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_pin_reset; $rose(aresetn) |-> !timer_output_pin; endproperty
  property p_pin_port;
    !sel_q && $past(!sel_q) && $past(!sel_q, 2) && $past(aresetn) && $past(aresetn, 2)
      |-> timer_output_pin == $past(port_out_level);
  endproperty
  property p_flag_sticky;
    $fell(overflow_irq_flag) && $past(aresetn) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_b_follows: assert property (p_b_follows) else $error("write response missing");
  a_r_follows: assert property (p_r_follows) else $error("read data missing");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_w_busy: assert property (p_w_busy) else $error("write accepted while busy");
  a_r_busy: assert property (p_r_busy) else $error("read accepted while busy");
  a_pin_reset: assert property (p_pin_reset) else $error("pin not low after reset");
  a_pin_port: assert property (p_pin_port) else $error("pin not port level");
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag fell without write");
endmodule // reload_timer_checker

// [sim/tb.sv]
// Self-checking bench for the reload timer.
`timescale 1ns/1ns
module tb;
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [13:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg [3:0] s_axi_wstrb, l;
  reg port_out_level, v, fast;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire timer_output_pin, overflow_irq_flag;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer fail_count, tests_run, seed, i, n;
  reg [1:0] rs;
  reg [31:0] rd;
  reload_timer i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_out_level(port_out_level),
    .timer_output_pin(timer_output_pin), .overflow_irq_flag(overflow_irq_flag)
  );
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  function lsb(input [31:0] x);
    lsb = x[0];
  endfunction
  // Prescaler division ratio for each clock select code.
  function integer div_of(input integer s);
    begin
      case (s)
        0: div_of = 2048;
        1: div_of = 512;
        2: div_of = 128;
        3: div_of = 32;
        4: div_of = 16;
        5: div_of = 8;
        6: div_of = 4;
        default: div_of = 1;
      endcase
    end
  endfunction
  always @(posedge aclk) port_out_level <= lsb($random(seed));
  task chk(input [33:0] g, input [33:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task end_sim;
    begin
      $display("Mismatches %0d in %0d checks", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task wr(input [13:0] a, input [31:0] d);
    reg ap, wp;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b0;
      ap = 1'b1;
      wp = 1'b1;
      fast = lsb($random(seed));
      forever begin
        @(posedge aclk);
        if (s_axi_bready === 1'b1 && s_axi_bvalid === 1'b1) begin
          rs = s_axi_bresp;
          break;
        end
        if (s_axi_awready) ap = 1'b0;
        if (s_axi_wready) wp = 1'b0;
        s_axi_awvalid <= ap;
        s_axi_wvalid <= wp;
        // A slow master raises bready only once it has seen bvalid.
        s_axi_bready <= !ap && !wp && (fast || s_axi_bvalid === 1'b1);
      end
    end
  endtask
  task rdr(input [13:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b0;
      fast = lsb($random(seed));
      forever begin
        @(posedge aclk);
        if (s_axi_rready === 1'b1 && s_axi_rvalid === 1'b1) begin
          rd = s_axi_rdata;
          rs = s_axi_rresp;
          break;
        end
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        s_axi_rready <= fast || s_axi_rvalid === 1'b1;
      end
    end
  endtask
  task wait_flag;
    begin
      n = 0;
      while (overflow_irq_flag !== 1'b1 && n < 40) begin
        @(posedge aclk);
        n = n + 1;
      end
    end
  endtask
  task edges(input integer c);
    begin
      n = 0;
      v = timer_output_pin;
      repeat (c) begin
        @(posedge aclk);
        if (timer_output_pin !== v) n = n + 1;
        v = timer_output_pin;
      end
    end
  endtask
  function [13:0] wo_addr(input integer k);
    wo_addr = (k == 0) ? 14'h2c : (k == 1) ? 14'h34 : 14'h48 + 4 * k;
  endfunction
  initial begin
    repeat (40000) @(posedge aclk);
    fail_count = fail_count + 1;
    end_sim;
  end
  initial begin
    seed = 32'h78116297;
    fail_count = 0;
    tests_run = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_bready, s_axi_rready} = 2'b00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 60'h0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk(overflow_irq_flag, 0);
    rdr(14'h64);
    chk({rs, rd}, 0);
    for (i = 0; i < 4; i = i + 1) begin
      rdr(wo_addr(i));
      chk({rs, rd}, 0);
    end
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge aclk);
      v = port_out_level;
      @(posedge aclk);
      chk(timer_output_pin, v);
    end
    rdr(14'h40);
    chk(rs, 2'b10);
    wr(14'h44, $random(seed));
    chk(rs, 2'b10);
    wr(14'h2d, 1);
    chk(rs, 2'b10);
    wr(14'h34, 1);
    wr(14'h50, 4'hf);
    rdr(14'h64);
    chk(rd[3:0], 0);
    rdr(14'h64);
    rdr(14'h64);
    chk(rd[3:0], 4'hf);
    wr(14'h58, 0);
    wr(14'h5c, 4'hf);
    rdr(14'h5c);
    chk(rd[3:0], 4'hf);
    rd = $random(seed);
    l = rd[3:0];
    wr(14'h58, l);
    rdr(14'h5c);
    rdr(14'h58);
    chk(rd[3:0], 0);
    wr(14'h5c, 4'hf);
    repeat (100) @(posedge aclk);
    rdr(14'h5c);
    chk(rd[3:0], 4'hf);
    rdr(14'h58);
    chk(rd[3:0], l);
    wr(14'h34, 0);
    wait_flag;
    chk(overflow_irq_flag, 1);
    for (i = 0; i < 4; i = i + 1) begin
      rdr(14'h5c);
      chk(rd[3:0], 4'hf);
    end
    rdr(14'h58);
    v = rd[0];
    l = rd[3:0];
    rdr(14'h58);
    chk(rd[3:0], l);
    wr(14'h34, 1);
    repeat (50) @(posedge aclk);
    chk(overflow_irq_flag, 1);
    wr(14'h60, 0);
    chk(overflow_irq_flag, 0);
    wr(14'h50, 4'h7);
    rdr(14'h64);
    rdr(14'h64);
    wr(14'h5c, 4'hf);
    wr(14'h34, 0);
    wait_flag;
    rdr(14'h5c);
    chk(rd[3:0], 0);
    wr(14'h2c, 1);
    edges(300);
    chk(n >= 1 && n <= 2, 1);
    wr(14'h58, 4'h8);
    wr(14'h54, 1);
    edges(600);
    chk(n >= 4, 1);
    // Reload FF overflows at every tick, so the pin toggles once per prescaler period.
    wr(14'h54, 0);
    wr(14'h58, 4'hf);
    for (i = 0; i < 8; i = i + 1) begin
      wr(14'h50, 8 + i);
      rdr(14'h64);
      rdr(14'h64);
      wr(14'h5c, 4'hf);
      repeat (2) @(posedge aclk);
      edges(4 * div_of(i));
      chk(n, 4);
    end
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk(overflow_irq_flag, 0);
    rdr(14'h64);
    chk({rs, rd}, 0);
    end_sim;
  end
endmodule // tb
bind reload_timer reload_timer_checker i_chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_out_level(port_out_level),
  .timer_output_pin(timer_output_pin), .overflow_irq_flag(overflow_irq_flag)
);
